/* wds_pkg.sv */
// constants for the watchdog and sleep sequencer
// Function
// R1: clearing poweron flag arms watchdog permanently
// R2: sleep timer on 32 kHz, overflow interrupts
// R3: third overflow raises watchdog reset
// R4: kick write clears watchdog; 0x38 clears timer
// R5: sleep only by sleep bit, until interrupt
// R6: detector duty cycled during sleep
// R7: slow oscillator keeps running in sleep
// R8: unmasked interrupt wakes, ignoring global enable
// R9: firmware keeps stop bit cleared
// R10: sleep forces internal clock, three-cycle recovery; code releases it when the cpu drops halt acknowledge, with no cycle count
// R11: next instruction runs before service routine
// R12: sleep bit raises halt request immediately
// R13: cpu acknowledges halt next rising edge
// R14: power down after acknowledge, falling edge
// R15: power down idles flash, oscillator, filter, bandgap
// R16: wake interrupt synced on slow falling edge
// R17: next slow rising edge drops power down
// R18: following rising edge samples comparators
// R19: next slow falling edge drops halt request
// R20: wake latency 75 to 105 us
// R21: sleep timer interrupt periodic when awake
// R22: firmware avoids slow clock for timers
// R23: poweron flag set by reset, blocks watchdog
// R24: dog reset flag set by hardware only
// R25: watchdog counter zero while disabled
package wds_pkg;
  localparam logic [8:0] WDS_ADDR_KICK = 9'h0e3;
  localparam logic [8:0] WDS_ADDR_SCR = 9'h0ff;
  localparam logic [8:0] WDS_ADDR_DUTY = 9'h1eb;
  localparam logic [8:0] WDS_ADDR_OSC = 9'h1e0;
  localparam logic [8:0] WDS_ADDR_CMP = 9'h1e4;
  localparam int WDS_SCR_DOG_FLAG = 5;
  localparam int WDS_SCR_PON_FLAG = 4;
  localparam int WDS_SCR_SLEEP = 3;
  localparam int WDS_SCR_STOP = 0;
  localparam logic [7:0] WDS_SCR_RESET = 8'h10;
  localparam logic [7:0] WDS_KICK_FULL = 8'h38;
  localparam logic [1:0] WDS_DOG_LIMIT = 2'h3;
  localparam logic [2:0] WDS_RECOVERY_CYCLES = 3'h3;
  localparam int WDS_SLOW_HZ = 32000;
  localparam int WDS_CLK_HZ = 50000000;
  localparam int WDS_SLOW_HALF = WDS_CLK_HZ / WDS_SLOW_HZ / 2;
  localparam logic [9:0] WDS_SLOW_HALF_CYC = 10'(WDS_SLOW_HALF);
  localparam int WDS_SLEEP_BITS = 16;
  // sleep period select: 2 bits, period = 64 << sel slow cycles
  localparam logic [15:0] WDS_SLEEP_BASE = 16'h0040;
  localparam logic [9:0] WDS_DUTY_PERIOD = 10'h200;
endpackage

/* wds_duty.sv */
// duty cycle generator for the detector during sleep
`timescale 1ns/100ps
`default_nettype none
module wds_duty
  import wds_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic slow_tick,
  input wire logic asleep,
  input wire logic [1:0] duty_sel,
  // result
  output logic detector_on
);
  logic [9:0] cnt_q;
  logic [9:0] on_len;
  logic on_q;

  // on time in slow cycles: 1/128, 1/512, 1/32, 1/8 of the window
  assign on_len = (duty_sel == 2'h0) ? 10'h004 :
                  (duty_sel == 2'h1) ? 10'h001 :
                  (duty_sel == 2'h2) ? 10'h010 : 10'h040;

  // free window counter on the slow tick
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 10'h000;
      on_q <= 1'b1;
    end else begin
      if (slow_tick) begin
        cnt_q <= (cnt_q == WDS_DUTY_PERIOD - 10'h001) ? 10'h000 :
                 cnt_q + 10'h001;
      end
      on_q <= !asleep || (cnt_q < on_len); // see R6
    end
  end
  assign detector_on = on_q;
endmodule
`default_nettype wire

/* wds_top.sv */
// watchdog, sleep timer and sleep/wake sequencer
`timescale 1ns/100ps
`default_nettype none
module wds_top
  import wds_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [8:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // cpu handshake
  input wire logic cpu_clock,
  input wire logic halt_acknowledge,
  input wire logic gie,
  input wire logic [7:0] irq_pending,
  output logic halt_request,
  output logic force_internal_clk,
  // system power
  output logic power_down,
  output logic detector_on,
  output logic [1:0] comparators_q,
  input wire logic [1:0] comparators,
  // events
  output logic sleep_irq,
  output logic watchdog_reset_event,
  output logic cpu_stopped
);
  // slow clock generation from clk
  logic [9:0] half_q;
  logic slow_q;
  logic slow_rise;
  logic slow_fall;
  // registers
  logic poweron_flag_q;
  logic dog_reset_flag_q;
  logic sleep_bit_q;
  logic stop_bit_q;
  logic [1:0] duty_q;
  logic [1:0] sleep_sel_q;
  logic low_power_osc_q;
  logic [1:0] watchdog_counter_q;
  logic [15:0] sleep_timer_q;
  logic dog_armed_q;
  logic cpu_clock_d1_q;
  logic cpu_fall;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] scr_word;
  logic duty_wr;
  logic osc_wr;
  logic scr_rd;
  logic duty_rd;
  logic osc_rd;
  logic cmp_rd;
  logic wake_irq;
  logic kick_wr;
  logic scr_wr;
  logic overflow;
  logic [15:0] sleep_limit;
  logic bite;

  typedef enum logic [2:0] {
    WDS_RUN, WDS_HALTREQ, WDS_POWERED_DOWN, WDS_SYNCED,
    WDS_POWER_UP, WDS_SAMPLED, WDS_RELEASE
  } wds_state_t;
  wds_state_t state_q;

  // address decode shared by writes and reads
  function automatic logic hit(input logic [8:0] a, input logic [8:0] r);
    hit = (a == r);
  endfunction

  assign kick_wr = wr && hit(addr, WDS_ADDR_KICK);
  assign scr_wr = wr && hit(addr, WDS_ADDR_SCR);
  // one strobe per register and direction, so the write and read paths share a decode
  assign duty_wr = wr && hit(addr, WDS_ADDR_DUTY);
  assign osc_wr = wr && hit(addr, WDS_ADDR_OSC);
  assign scr_rd = rd && hit(addr, WDS_ADDR_SCR);
  assign duty_rd = rd && hit(addr, WDS_ADDR_DUTY);
  assign osc_rd = rd && hit(addr, WDS_ADDR_OSC);
  assign cmp_rd = rd && hit(addr, WDS_ADDR_CMP);
  assign sleep_limit = WDS_SLEEP_BASE << sleep_sel_q;
  // overflow counts during sleep too, oscillator never stops
  assign overflow = slow_rise && (sleep_timer_q == sleep_limit - 16'h0001);
  // global interrupt enable deliberately not part of wake
  assign wake_irq = |irq_pending; // see R8
  assign cpu_fall = cpu_clock_d1_q && !cpu_clock;
  assign bite = dog_armed_q && !poweron_flag_q && overflow &&
                (watchdog_counter_q == WDS_DOG_LIMIT - 2'h1);

  // 32 kHz reference kept running always
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      half_q <= 10'h000;
      slow_q <= 1'b0;
    end else begin
      half_q <= (half_q == WDS_SLOW_HALF_CYC - 10'h001) ? 10'h000 :
                half_q + 10'h001; // see R7
      if (half_q == WDS_SLOW_HALF_CYC - 10'h001) begin
        slow_q <= !slow_q;
      end
    end
  end
  assign slow_rise = (half_q == WDS_SLOW_HALF_CYC - 10'h001) && !slow_q;
  assign slow_fall = (half_q == WDS_SLOW_HALF_CYC - 10'h001) && slow_q;

  // sleep timer on the slow clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sleep_timer_q <= 16'h0000;
    end else if (kick_wr && wdata == WDS_KICK_FULL) begin
      sleep_timer_q <= 16'h0000; // see R4
    end else if (slow_rise) begin
      sleep_timer_q <= overflow ? 16'h0000 :
                       sleep_timer_q + 16'h0001; // see R2
    end
  end

  // overflow interrupt, awake or asleep
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sleep_irq <= 1'b0;
    end else begin
      sleep_irq <= overflow; // see R2 R21
    end
  end

  // arming: only a power-on reset disarms, software cannot
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dog_armed_q <= 1'b0;
    end else if (!poweron_flag_q) begin
      dog_armed_q <= 1'b1; // see R1
    end
  end

  // watchdog counter of overflows
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      watchdog_counter_q <= 2'h0;
    end else if (!dog_armed_q || poweron_flag_q) begin
      watchdog_counter_q <= 2'h0; // see R25 R23
    end else if (kick_wr) begin
      watchdog_counter_q <= 2'h0; // see R4
    end else if (overflow) begin
      watchdog_counter_q <= bite ? 2'h0 :
                            watchdog_counter_q + 2'h1; // see R3
    end
  end

  // reset pulse to the system
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      watchdog_reset_event <= 1'b0;
    end else begin
      watchdog_reset_event <= bite; // see R3
    end
  end

  // status and control; hardware set wins over a software clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      poweron_flag_q <= WDS_SCR_RESET[WDS_SCR_PON_FLAG]; // see R23
      dog_reset_flag_q <= WDS_SCR_RESET[WDS_SCR_DOG_FLAG];
      stop_bit_q <= WDS_SCR_RESET[WDS_SCR_STOP];
    end else begin
      if (scr_wr && !wdata[WDS_SCR_PON_FLAG]) begin
        poweron_flag_q <= 1'b0; // see R23
      end
      if (bite) begin
        dog_reset_flag_q <= 1'b1; // see R24
      end else if (scr_wr && !wdata[WDS_SCR_DOG_FLAG]) begin
        dog_reset_flag_q <= 1'b0;
      end
      if (scr_wr) begin
        stop_bit_q <= wdata[WDS_SCR_STOP]; // see R9
      end
    end
  end

  // other control fields
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      duty_q <= 2'h0;
      sleep_sel_q <= 2'h0;
      low_power_osc_q <= 1'b0;
    end else begin
      if (duty_wr) begin
        duty_q <= wdata[7:6];
      end
      if (osc_wr) begin
        low_power_osc_q <= wdata[7]; // see R7
        sleep_sel_q <= wdata[4:3];
      end
    end
  end

  // cpu clock sampled for its falling edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cpu_clock_d1_q <= 1'b0;
    end else begin
      cpu_clock_d1_q <= cpu_clock;
    end
  end

  // sleep and wake sequencer; wake spans 2 to 3 slow periods, see R20
  // the fixed slow-edge steps keep the latency window set by the
  // reference alone, whatever the cpu clock rate happens to be
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= WDS_RUN;
      sleep_bit_q <= 1'b0;
      comparators_q <= 2'h0;
    end else begin
      case (state_q)
        WDS_RUN: begin
          if (scr_wr && wdata[WDS_SCR_SLEEP]) begin
            sleep_bit_q <= 1'b1; // see R5
            state_q <= WDS_HALTREQ;
          end
        end
        WDS_HALTREQ: begin
          if (halt_acknowledge && cpu_fall) begin
            state_q <= WDS_POWERED_DOWN; // see R13 R14
          end
        end
        WDS_POWERED_DOWN: begin
          if (wake_irq && !stop_bit_q && slow_fall) begin
            state_q <= WDS_SYNCED; // see R16 R9
          end
        end
        WDS_SYNCED: begin
          if (slow_rise) begin
            state_q <= WDS_POWER_UP; // see R17
          end
        end
        WDS_POWER_UP: begin
          if (slow_rise) begin
            comparators_q <= comparators; // see R18
            state_q <= WDS_SAMPLED;
          end
        end
        WDS_SAMPLED: begin
          if (slow_fall) begin
            sleep_bit_q <= 1'b0; // see R19
            state_q <= WDS_RELEASE;
          end
        end
        WDS_RELEASE: begin
          if (!halt_acknowledge) begin
            state_q <= WDS_RUN; // see R11 R19
          end
        end
        default: begin
          state_q <= WDS_RUN;
        end
      endcase
    end
  end

  // request asserted combinationally in the write cycle
  assign halt_request = sleep_bit_q ||
                        (state_q == WDS_RUN && scr_wr &&
                         wdata[WDS_SCR_SLEEP]); // see R12
  // power down covers flash, oscillator, filter and bandgap
  assign power_down = (state_q == WDS_POWERED_DOWN) ||
                      (state_q == WDS_SYNCED); // see R15 R17
  // held until the cpu drops halt acknowledge after wake
  assign force_internal_clk = (state_q != WDS_RUN); // see R10
  assign cpu_stopped = stop_bit_q;

  wds_duty u_duty (
    .clk(clk),
    .nrst(nrst),
    .slow_tick(slow_rise),
    .asleep(power_down),
    .duty_sel(duty_q),
    .detector_on(detector_on)
  );

  // status word as software sees it; reserved bits read zero
  assign scr_word = {gie, 1'b0, dog_reset_flag_q, poweron_flag_q,
                     sleep_bit_q, 2'h0, stop_bit_q};
  // read selection; the kick register and unmapped space read zero
  assign rdata_d = scr_rd ? scr_word :
                   duty_rd ? {duty_q, 6'h00} :
                   osc_rd ? {low_power_osc_q, 2'h0, sleep_sel_q, 3'h0} :
                   cmp_rd ? {6'h00, comparators_q} : 8'h00;

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d; // see R4
    end
  end
  assign rdata = rdata_q;
endmodule
`default_nettype wire

/* wds_top_sva.sv */
// port assertions for the watchdog and sleep sequencer
`timescale 1ns/100ps
`default_nettype none
module wds_top_sva
  import wds_pkg::*;
(
  // clock, reset and register port
  input wire logic clk,
  input wire logic nrst,
  input wire logic [8:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // sequencing
  input wire logic cpu_clock,
  input wire logic halt_acknowledge,
  input wire logic halt_request,
  input wire logic force_internal_clk,
  input wire logic power_down,
  input wire logic [1:0] comparators_q,
  input wire logic sleep_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [11:0] gap_q;
  logic [11:0] gap_d;
  wire logic sleep_wr = wr && addr == WDS_ADDR_SCR && wdata[WDS_SCR_SLEEP];
  // cycles since power down fell; saturates so a stale gap never matches
  assign gap_d = power_down ? 12'h000 : gap_q + {11'h000, ~&gap_q};
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) gap_q <= 12'hfff;
    else gap_q <= gap_d;
  property p_halt_now; sleep_wr |-> halt_request; endproperty
  a_halt_now: assert property (p_halt_now) else $error("halt late");
  property p_sleep_src; $rose(halt_request) |-> sleep_wr; endproperty
  a_sleep_src: assert property (p_sleep_src) else $error("bad sleep");
  property p_down_ack; $rose(power_down) |-> halt_acknowledge && !cpu_clock;
  endproperty
  a_down_ack: assert property (p_down_ack) else $error("down early");
  property p_down_hold; power_down |-> halt_request && force_internal_clk;
  endproperty
  a_down_hold: assert property (p_down_hold) else $error("down alone");
  // three slow half periods from power up to release of the cpu
  property p_gap; $fell(halt_request) |-> gap_q >= 12'h920 && gap_q <= 12'h92e;
  endproperty
  a_gap: assert property (p_gap) else $error("bad wake gap");
  property p_cmp; $changed(comparators_q) |-> halt_request && !power_down;
  endproperty
  a_cmp: assert property (p_cmp) else $error("bad sample");
  property p_kick_rd; rd && addr == WDS_ADDR_KICK |=> rdata == 8'h00;
  endproperty
  a_kick_rd: assert property (p_kick_rd) else $error("kick readable");
  property p_irq_pulse; sleep_irq |=> !sleep_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("long irq");
  // main scenarios
  c_sleep: cover property ($rose(power_down));
  c_wake: cover property ($fell(halt_request));
  c_tick: cover property (sleep_irq);
endmodule
bind wds_top wds_top_sva i_wds_top_sva (.clk, .nrst, .addr, .wdata, .wr, .rd,
  .rdata, .cpu_clock, .halt_acknowledge, .halt_request, .force_internal_clk,
  .power_down, .comparators_q, .sleep_irq);
`default_nettype wire

/* wds_cpu_model.sv */
// cpu core stand-in: makes the cpu clock and answers halt requests
`timescale 1ns/100ps
`default_nettype none
module wds_cpu_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // handshake
  input wire logic halt_request,
  input wire logic power_down,
  output logic cpu_clock,
  output logic halt_acknowledge
);
  logic [2:0] div_q;
  // no timer clock is taken from the slow reference here
  // cpu clock at a tenth of clk, stopped while powered down
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= 3'h0;
      cpu_clock <= 1'b0;
      halt_acknowledge <= 1'b0;
    end else if (!power_down) begin
      div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
      if (div_q == 3'h4) begin
        cpu_clock <= ~cpu_clock;
        if (!cpu_clock) halt_acknowledge <= halt_request;
      end
    end
  end
endmodule
`default_nettype wire

/* test_wds_top.sv */
// self-checking bench for the watchdog and sleep sequencer
`timescale 1ns/100ps
`default_nettype none
module test_wds_top;
  import wds_pkg::*;
  logic clk, nrst, wr, rd, gie, cpu_clock, halt_acknowledge, halt_request;
  logic force_internal_clk, power_down, detector_on;
  logic sleep_irq, watchdog_reset_event, cpu_stopped;
  logic [8:0] addr;
  logic [7:0] wdata, rdata, irq_pending;
  logic [7:0] osc_v;
  logic [1:0] comparators, comparators_q, cmp_v;
  int err_total, samples_checked, n;
  wds_top i_wds_top (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .cpu_clock,
    .halt_acknowledge, .gie, .irq_pending, .halt_request, .force_internal_clk,
    .power_down, .detector_on, .comparators_q, .comparators, .sleep_irq,
    .watchdog_reset_event, .cpu_stopped);
  wds_cpu_model i_wds_cpu_model (.clk, .nrst, .halt_request, .power_down,
    .cpu_clock, .halt_acknowledge);
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task wrap_up();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd_chk(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic wait_on(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    if (s !== v) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, s, v);
      wrap_up();
    end
  endtask
  // main sequence
  initial begin
    nrst = 1'b0;
    {addr, wdata, wr, rd, irq_pending} = '0;
    n = $urandom(27);
    gie = 1'($urandom);
    comparators = 2'($urandom);
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(WDS_ADDR_SCR, {gie, 7'h10});
    rd_chk(WDS_ADDR_KICK, 8'h00);
    rd_chk(9'h1ff, 8'h00);
    wr_reg(WDS_ADDR_KICK, WDS_KICK_FULL);
    wr_reg(WDS_ADDR_KICK, 8'($urandom));
    wr_reg(WDS_ADDR_SCR, 8'h20);
    rd_chk(WDS_ADDR_SCR, {gie, 7'h00});
    // shortest detector on time, so it is off while asleep
    wr_reg(WDS_ADDR_DUTY, 8'h40);
    rd_chk(WDS_ADDR_DUTY, 8'h40);
    osc_v = 8'($urandom);
    wr_reg(WDS_ADDR_OSC, osc_v);
    rd_chk(WDS_ADDR_OSC, osc_v & 8'h98);
    // sleep and wake with the global enable both off and on
    for (int i = 0; i < 2; i++) begin
      cmp_v = 2'($urandom);
      @(posedge clk);
      comparators <= cmp_v;
      gie <= i[0];
      wr_reg(WDS_ADDR_SCR, 8'h08);
      wait_on(power_down, 1'b1, 40);
      repeat (2000) @(posedge clk);
      #1 chk({7'h0, power_down}, 8'h01);
      chk({7'h0, force_internal_clk}, 8'h01);
      chk({7'h0, detector_on}, 8'h00);
      @(posedge clk);
      irq_pending <= 8'h01 << ($urandom % 8);
      wait_on(halt_request, 1'b0, 6000);
      chk({7'h0, n <= 5250}, 8'h01);
      chk({6'h0, comparators_q}, {6'h0, cmp_v});
      @(posedge clk);
      irq_pending <= 8'h00;
      wait_on(halt_acknowledge, 1'b0, 20);
      chk({7'h0, detector_on}, 8'h01);
      rd_chk(WDS_ADDR_CMP, {6'h0, cmp_v});
      chk({7'h0, force_internal_clk}, 8'h00);
    end
    wr_reg(WDS_ADDR_SCR, 8'h01);
    #1 chk({7'h0, cpu_stopped}, 8'h01);
    chk({7'h0, watchdog_reset_event}, 8'h00);
    // second reset in mid run restores the power-on flag
    @(posedge clk);
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(WDS_ADDR_SCR, {gie, 7'h10});
    chk({7'h0, cpu_stopped}, 8'h00);
    chk({7'h0, detector_on}, 8'h01);
    wrap_up();
  end
endmodule
`default_nettype wire
